// ===== rtl/cell_queue_pkg.sv
/*
 shared constants and types for the cell queue control and status block:
 register offsets, field positions, reset values, cell counts and the
 carriers for the sampled link pins and the transmit events.
 assumes an 8-bit register port and byte-wide cell transfer on the link.
*/
package cell_queue_pkg;

	// register offsets
	localparam logic [7:0] RX_ADDR_OFFSET = 8'h6c;
	localparam logic [7:0] RX_STATUS_OFFSET = 8'h6d;
	localparam logic [7:0] TX_CTRL_OFFSET = 8'h6e;
	localparam logic [7:0] EVENT_CLEAR_OFFSET = 8'h73;

	// transmit control and status fields
	localparam int TX_RESET_BIT = 7;
	localparam int DROP_BIT = 6;
	localparam int IRQ_EN_LSB = 3;
	localparam int FLAG_LSB = 0;
	localparam int EVENT_W = 3;

	// receive status fields
	localparam int RX_DEPTH_BIT = 7;
	localparam int RX_RSVD_BIT = 6;
	localparam int RX_FULL_BIT = 1;
	localparam int RX_EMPTY_BIT = 0;

	// receive address field
	localparam int RX_ADDR_W = 5;
	localparam logic [4:0] RX_ADDR_RESET = 5'h00;

	// reset values of control bits and read data
	localparam logic TX_RESET_RESET = 1'b0;
	localparam logic DROP_RESET = 1'b0;
	localparam logic RX_DEEP_RESET = 1'b0;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// cell and queue counts
	localparam int CELL_BYTES_DEFAULT = 53;
	localparam int SLOT_BITS = 6;
	localparam int TX_DEPTH_DEFAULT = 16;
	localparam int RX_DEEP_DEFAULT = 16;
	localparam int RX_SHALLOW_DEFAULT = 4;

	typedef struct packed {
		logic parity;
		logic overrun;
		logic short_cell;
	} tx_event_type;

	typedef struct packed {
		logic [4:0] rx_addr;
		logic link_clk;
		logic enb_n;
		logic soc;
		logic prty;
		logic [7:0] data;
	} link_sample_type;

endpackage

// ===== rtl/link_sync.sv
/*
 three-stage synchroniser for a group of pins from outside the clock domain.
 the output only follows a bit once the second and third stages agree.
 assumes the pins hold each value for several clock periods.
*/
`timescale 1ns/10ps
module link_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] sync_next;

	// stage1 feeds only stage2; a disagreeing bit keeps its old value
	always_comb begin
		sync_next = (stage2_reg & stage3_reg) | (sync_out & (stage2_reg ^ stage3_reg));
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			sync_out <= sync_next;
		end
	end

endmodule // link_sync

// ===== rtl/cell_queue_ram.sv
/*
 simple dual-port byte store for the transmit cell queue, one write port
 and one read port whose data come out of a register one cycle later.
 assumes the caller never needs the contents cleared, only the pointers.
*/
`timescale 1ns/10ps
module cell_queue_ram #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 10
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);

	logic [DATA_W-1:0] mem [2**ADDR_W];

	// no reset on the array so it maps onto block memory
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule // cell_queue_ram

// ===== rtl/utopia_cell_queue_ctrl_status.sv
/*
 control and status registers for the receive and transmit cell queues
 behind the cell bus, with the transmit cell assembler and queue they steer.
 assumes a same-clock register port, a cell-bus clock far slower than clk,
 and a framer that reports receive queue traffic with one-cycle pulses.
*/
// Overview of operation
// - five-bit receive bus address, resets to zero
// - depth bit picks four or sixteen cells
// - read-only full flag while queue is full
// - read-only empty flag, set after reset
// - rising reset bit flushes transmit queue
// - drop bit discards cells with parity errors
// - event flags stick until transmit control register read or clear write
// - cell intake, flush, depth bit, clav and irq act only in cell mode
`timescale 1ns/10ps
module utopia_cell_queue_ctrl_status
	import cell_queue_pkg::*;
#(
	parameter int CELL_BYTES = CELL_BYTES_DEFAULT,
	parameter int TX_DEPTH = TX_DEPTH_DEFAULT,
	parameter int RX_DEEP = RX_DEEP_DEFAULT,
	parameter int RX_SHALLOW = RX_SHALLOW_DEFAULT
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic atm_cell_mode,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	input wire logic utopia_clk,
	input wire logic tx_enb_n,
	input wire logic tx_soc,
	input wire logic [7:0] tx_data,
	input wire logic tx_prty,
	output logic tx_clav,
	input wire logic [4:0] rx_addr_in,
	output logic rx_clav,
	input wire logic rx_cell_in,
	input wire logic rx_cell_out,
	output logic tx_out_valid,
	input wire logic tx_out_ready,
	output logic [7:0] tx_out_data,
	output logic tx_out_soc
);

	localparam int CW = $clog2(TX_DEPTH);
	localparam int RXW = $clog2(RX_DEEP + 1);
	localparam int RAM_AW = CW + SLOT_BITS;
	localparam logic [CW:0] TX_FULL_COUNT = (CW + 1)'(TX_DEPTH);
	localparam logic [SLOT_BITS-1:0] LAST_BYTE = SLOT_BITS'(CELL_BYTES - 1);
	localparam logic [RXW-1:0] RX_DEEP_COUNT = RXW'(RX_DEEP);
	localparam logic [RXW-1:0] RX_SHALLOW_COUNT = RXW'(RX_SHALLOW);

	link_sample_type link_in;
	link_sample_type link_s;
	logic [$bits(link_sample_type)-1:0] link_s_bits;

	// software-visible state
	logic [RX_ADDR_W-1:0] rx_addr_reg, rx_addr_next;
	logic rx_deep_reg, rx_deep_next;
	logic rx_rsvd_reg, rx_rsvd_next;
	logic tx_reset_bit_reg, tx_reset_bit_next;
	logic drop_cell_on_parity_error_reg, drop_cell_on_parity_error_next;
	tx_event_type irq_en_reg, irq_en_next;
	tx_event_type flag_reg, flag_next;
	logic [7:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;

	// link-facing and queue state
	logic clk_prev_reg, clk_prev_next;
	logic [SLOT_BITS-1:0] asm_cnt_reg, asm_cnt_next;
	logic asm_perr_reg, asm_perr_next;
	logic asm_ovf_reg, asm_ovf_next;
	logic [CW-1:0] wr_cell_reg, wr_cell_next;
	logic [CW-1:0] rd_cell_reg, rd_cell_next;
	logic [CW:0] tx_count_reg, tx_count_next;
	logic [SLOT_BITS-1:0] rd_byte_reg, rd_byte_next;
	logic pend_reg, pend_next;
	logic out_valid_reg, out_valid_next;
	logic [7:0] out_byte_reg, out_byte_next;
	logic out_soc_reg, out_soc_next;
	logic [RXW-1:0] rx_count_reg, rx_count_next;
	logic tx_clav_reg, tx_clav_next;
	logic rx_clav_reg, rx_clav_next;

	// combinational helpers
	logic take;
	logic par_bad;
	logic tx_full;
	logic flush;
	logic push;
	logic pop;
	logic rd_issue;
	logic ram_wr;
	logic [RAM_AW-1:0] ram_waddr;
	logic [7:0] ram_rdata;
	logic [RXW-1:0] rx_depth;
	logic rx_full;
	logic rx_empty;
	tx_event_type ev;
	tx_event_type clr;

	always_comb begin
		link_in.rx_addr = rx_addr_in;
		link_in.link_clk = utopia_clk;
		link_in.enb_n = tx_enb_n;
		link_in.soc = tx_soc;
		link_in.prty = tx_prty;
		link_in.data = tx_data;
		link_s = link_sample_type'(link_s_bits);
	end

	link_sync #(
		.WIDTH($bits(link_sample_type))
	) pin_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(link_in),
		.sync_out(link_s_bits)
	);

	cell_queue_ram #(
		.DATA_W(8),
		.ADDR_W(RAM_AW)
	) transmit_cell_queue (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(ram_wr),
		.wr_addr(ram_waddr),
		.wr_data(link_s.data),
		.rd_addr({rd_cell_reg, rd_byte_reg}),
		.rd_data(ram_rdata)
	);

	always_comb begin
		rx_addr_next = rx_addr_reg;
		rx_deep_next = rx_deep_reg;
		rx_rsvd_next = rx_rsvd_reg;
		tx_reset_bit_next = tx_reset_bit_reg;
		drop_cell_on_parity_error_next = drop_cell_on_parity_error_reg;
		irq_en_next = irq_en_reg;
		clk_prev_next = link_s.link_clk;
		asm_cnt_next = asm_cnt_reg;
		asm_perr_next = asm_perr_reg;
		asm_ovf_next = asm_ovf_reg;
		wr_cell_next = wr_cell_reg;
		rd_cell_next = rd_cell_reg;
		rd_byte_next = rd_byte_reg;
		out_valid_next = out_valid_reg;
		out_byte_next = out_byte_reg;
		out_soc_next = out_soc_reg;
		ev = '0;
		clr = '0;
		push = 1'b0;
		pop = 1'b0;
		ram_wr = 1'b0;
		ram_waddr = {wr_cell_reg, asm_cnt_reg};
		flush = 1'b0;

		// bytes are taken at the falling link edge: the master moves data on the
		// rising edge, so mid-period is the only point the synced copy is steady
		take = atm_cell_mode & clk_prev_reg & ~link_s.link_clk & ~link_s.enb_n;
		par_bad = ~^{link_s.data, link_s.prty};
		tx_full = tx_count_reg == TX_FULL_COUNT;

		if (take) begin
			ev.parity = par_bad;
			if (link_s.soc) begin
				ev.short_cell = asm_cnt_reg != '0;
				ev.overrun = tx_full;
				asm_ovf_next = tx_full;
				asm_perr_next = par_bad;
				ram_wr = ~tx_full;
				ram_waddr = {wr_cell_reg, {SLOT_BITS{1'b0}}};
				asm_cnt_next = SLOT_BITS'(1);
			end else if (asm_cnt_reg != '0) begin
				asm_perr_next = asm_perr_reg | par_bad;
				ram_wr = ~asm_ovf_reg;
				asm_cnt_next = SLOT_BITS'(asm_cnt_reg + 1'b1);
			end
			if ((link_s.soc ? '0 : asm_cnt_reg) == LAST_BYTE && (link_s.soc || asm_cnt_reg != '0)) begin
				asm_cnt_next = '0;
				// a runt simply leaves its slot uncommitted, so the next cell overwrites it
				push = ~asm_ovf_next & ~(asm_perr_next & drop_cell_on_parity_error_reg);
			end
		end
		if (push) begin
			wr_cell_next = CW'(wr_cell_reg + 1'b1);
		end

		// drain one byte per three cycles at best, ample against the link byte rate
		rd_issue = tx_count_reg != '0 && !pend_reg && !out_valid_reg;
		pend_next = rd_issue;
		if (pend_reg) begin
			out_valid_next = 1'b1;
			out_byte_next = ram_rdata;
			out_soc_next = rd_byte_reg == '0;
		end
		if (out_valid_reg && tx_out_ready) begin
			out_valid_next = 1'b0;
			if (rd_byte_reg == LAST_BYTE) begin
				rd_byte_next = '0;
				rd_cell_next = CW'(rd_cell_reg + 1'b1);
				pop = 1'b1;
			end else begin
				rd_byte_next = SLOT_BITS'(rd_byte_reg + 1'b1);
			end
		end
		tx_count_next = (CW + 1)'(tx_count_reg + push - pop);

		// register writes
		if (reg_wr) begin
			unique case (reg_addr)
				RX_ADDR_OFFSET: rx_addr_next = reg_wdata[RX_ADDR_W-1:0];
				RX_STATUS_OFFSET: begin
					rx_deep_next = reg_wdata[RX_DEPTH_BIT];
					rx_rsvd_next = reg_wdata[RX_RSVD_BIT];
				end
				TX_CTRL_OFFSET: begin
					tx_reset_bit_next = reg_wdata[TX_RESET_BIT];
					drop_cell_on_parity_error_next = reg_wdata[DROP_BIT];
					irq_en_next = reg_wdata[IRQ_EN_LSB +: EVENT_W];
					flush = atm_cell_mode & reg_wdata[TX_RESET_BIT] & ~tx_reset_bit_reg;
				end
				EVENT_CLEAR_OFFSET: clr = reg_wdata[FLAG_LSB +: EVENT_W];
				default: ;
			endcase
		end

		// a rising reset bit wins over any traffic in the same cycle
		if (flush) begin
			asm_cnt_next = '0;
			asm_perr_next = 1'b0;
			asm_ovf_next = 1'b0;
			wr_cell_next = '0;
			rd_cell_next = '0;
			rd_byte_next = '0;
			tx_count_next = '0;
			pend_next = 1'b0;
			out_valid_next = 1'b0;
			ram_wr = 1'b0;
		end

		// receive queue occupancy; depth bit ignored outside cell mode
		rx_depth = (atm_cell_mode && rx_deep_reg) ? RX_DEEP_COUNT : RX_SHALLOW_COUNT;
		rx_full = rx_count_reg >= rx_depth;
		rx_empty = rx_count_reg == '0;
		rx_count_next = RXW'(rx_count_reg + (rx_cell_in & ~rx_full) - (rx_cell_out & ~rx_empty));
		rx_clav_next = atm_cell_mode & ~rx_empty & (link_s.rx_addr == rx_addr_reg);
		tx_clav_next = atm_cell_mode & (tx_count_next != TX_FULL_COUNT);

		// register reads: data stand one cycle, then return to zero
		rdata_next = RDATA_RESET;
		if (reg_rd) begin
			unique case (reg_addr)
				RX_ADDR_OFFSET: rdata_next = {3'h0, rx_addr_reg};
				RX_STATUS_OFFSET: rdata_next = {rx_deep_reg, rx_rsvd_reg, 4'h0, rx_full, rx_empty};
				TX_CTRL_OFFSET: begin
					rdata_next = {tx_reset_bit_reg, drop_cell_on_parity_error_reg, irq_en_reg, flag_reg};
					clr = '1;
				end
				default: rdata_next = RDATA_RESET;
			endcase
		end

		// a new event in the clearing cycle survives the clear
		flag_next = (flag_reg & ~clr) | ev;
		irq_next = atm_cell_mode & |(flag_next & irq_en_next);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_addr_reg <= RX_ADDR_RESET;
			rx_deep_reg <= RX_DEEP_RESET;
			rx_rsvd_reg <= 1'b0;
			tx_reset_bit_reg <= TX_RESET_RESET;
			drop_cell_on_parity_error_reg <= DROP_RESET;
			irq_en_reg <= '0;
			flag_reg <= '0;
			rdata_reg <= RDATA_RESET;
			irq_reg <= 1'b0;
			clk_prev_reg <= 1'b0;
			asm_cnt_reg <= '0;
			asm_perr_reg <= 1'b0;
			asm_ovf_reg <= 1'b0;
			wr_cell_reg <= '0;
			rd_cell_reg <= '0;
			tx_count_reg <= '0;
			rd_byte_reg <= '0;
			pend_reg <= 1'b0;
			out_valid_reg <= 1'b0;
			out_byte_reg <= 8'h00;
			out_soc_reg <= 1'b0;
			rx_count_reg <= '0;
			tx_clav_reg <= 1'b0;
			rx_clav_reg <= 1'b0;
		end else begin
			rx_addr_reg <= rx_addr_next;
			rx_deep_reg <= rx_deep_next;
			rx_rsvd_reg <= rx_rsvd_next;
			tx_reset_bit_reg <= tx_reset_bit_next;
			drop_cell_on_parity_error_reg <= drop_cell_on_parity_error_next;
			irq_en_reg <= irq_en_next;
			flag_reg <= flag_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			clk_prev_reg <= clk_prev_next;
			asm_cnt_reg <= asm_cnt_next;
			asm_perr_reg <= asm_perr_next;
			asm_ovf_reg <= asm_ovf_next;
			wr_cell_reg <= wr_cell_next;
			rd_cell_reg <= rd_cell_next;
			tx_count_reg <= tx_count_next;
			rd_byte_reg <= rd_byte_next;
			pend_reg <= pend_next;
			out_valid_reg <= out_valid_next;
			out_byte_reg <= out_byte_next;
			out_soc_reg <= out_soc_next;
			rx_count_reg <= rx_count_next;
			tx_clav_reg <= tx_clav_next;
			rx_clav_reg <= rx_clav_next;
		end
	end

	always_comb begin
		reg_rdata = rdata_reg;
		irq = irq_reg;
		tx_clav = tx_clav_reg;
		rx_clav = rx_clav_reg;
		tx_out_valid = out_valid_reg;
		tx_out_data = out_byte_reg;
		tx_out_soc = out_soc_reg;
	end

endmodule // utopia_cell_queue_ctrl_status

// ===== verification/cell_queue_assertions.sv
/*
 concurrent checks on the register port, interrupt, link status and drain outputs.
 assumes one clock domain; bound into the block at the foot of this file.
*/
`timescale 1ns/10ps
module cell_queue_assertions
	import cell_queue_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic atm_cell_mode,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq,
	input wire logic tx_clav,
	input wire logic rx_clav,
	input wire logic tx_out_valid,
	input wire logic tx_out_ready,
	input wire logic [7:0] tx_out_data,
	input wire logic tx_out_soc
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence wr_rd(a);
		reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
	endsequence

	sequence quiet_then_irq_read;
		!(reg_wr || reg_rd) ##1 irq && !(reg_wr || reg_rd) ##1 reg_rd && reg_addr == TX_CTRL_OFFSET;
	endsequence

	addr_readback_a: assert property (wr_rd(RX_ADDR_OFFSET) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f))
		else $error("rx address readback wrong");
	depth_readback_a: assert property (atm_cell_mode ##0 wr_rd(RX_STATUS_OFFSET) |=>
		reg_rdata[7] == $past(reg_wdata[7], 2)) else $error("depth bit readback wrong");
	status_flags_a: assert property (reg_rd && reg_addr == RX_STATUS_OFFSET |=>
		!(reg_rdata[1] && reg_rdata[0]) && reg_rdata[4:2] == 3'b000) else $error("rx status flags wrong");
	ctrl_readback_a: assert property (atm_cell_mode ##0 wr_rd(TX_CTRL_OFFSET) |=>
		reg_rdata[7:3] == $past(reg_wdata[7:3], 2)) else $error("tx control readback wrong");
	irq_source_a: assert property (reg_rd && reg_addr == TX_CTRL_OFFSET ##1 (|(reg_rdata[5:3] & reg_rdata[2:0]))
		|-> irq || $past(irq)) else $error("enabled flag without interrupt");
	irq_flag_a: assert property (quiet_then_irq_read |=> |(reg_rdata[5:3] & reg_rdata[2:0]))
		else $error("interrupt without enabled flag");
	clear_quiet_a: assert property (!atm_cell_mode && !$past(atm_cell_mode) |-> !irq && !tx_clav && !rx_clav)
		else $error("activity in clear channel mode");
	drain_hold_a: assert property (tx_out_valid && !tx_out_ready && !reg_wr |=>
		tx_out_valid && $stable(tx_out_data) && $stable(tx_out_soc)) else $error("offered byte not held");
	drain_rate_a: assert property (tx_out_valid && tx_out_ready |=> !tx_out_valid [*2])
		else $error("drain faster than contract");
endmodule // cell_queue_assertions

bind utopia_cell_queue_ctrl_status cell_queue_assertions checker_i (.*);

// ===== verification/atm_layer_model.sv
/*
 behavioural cell-bus master that sends transmit cells with odd parity.
 assumes the caller sequences cells; the link clock stands still between frames.
*/
`timescale 1ns/10ps
module atm_layer_model (
	output logic utopia_clk,
	output logic tx_enb_n,
	output logic tx_soc,
	output logic [7:0] tx_data,
	output logic tx_prty
);
	initial begin
		utopia_clk = 1'b0;
		tx_enb_n = 1'b1;
		tx_soc = 1'b0;
		tx_data = 8'h00;
		tx_prty = 1'b1;
	end

	// bytes run 0x30 upward so the first byte is recognisable at the drain
	task automatic send_cell(input int len, input int bad_at);
		// step 10 ns off the entry time; a call entered on a rising clk edge never changes a pin in the time step that samples it
		#10;
		for (int i = 0; i < len; i++) begin
			tx_enb_n = 1'b0;
			tx_soc = (i == 0);
			tx_data = 8'h30 + i[7:0];
			tx_prty = ~^tx_data ^ (i == bad_at);
			#80 utopia_clk = 1'b1;
			#160 utopia_clk = 1'b0;
			#80;
		end
		// released pins must not look like a held byte
		tx_enb_n = 1'b1;
		tx_soc = 1'b0;
		tx_data = ~tx_data;
		tx_prty = ~tx_prty;
	endtask
endmodule // atm_layer_model

// ===== verification/utopia_cell_queue_ctrl_status_test.sv
/*
 self-checking bench: register reads and writes, receive occupancy, transmit cells.
 assumes the atm_layer_model partner and the bound assertion checker.
*/
`timescale 1ns/10ps
module utopia_cell_queue_ctrl_status_test;
	import cell_queue_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, atm_cell_mode = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tx_data, tx_out_data, pins;
	logic irq, utopia_clk, tx_enb_n, tx_soc, tx_prty, tx_clav, rx_clav, tx_out_valid, tx_out_soc;
	logic [4:0] rx_addr_in = 5'h15;
	logic rx_cell_in = 1'b0, rx_cell_out = 1'b0, tx_out_ready = 1'b1;
	int err_total = 0, samples_checked = 0;

	always #20 clk = ~clk;
	utopia_cell_queue_ctrl_status dut (.*);
	atm_layer_model link (.*);
	assign pins = {3'b000, irq, tx_clav, rx_clav, tx_out_valid, tx_out_soc};

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// entered just after a rising edge, returns on one
	task rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk("reg_rdata", exp, reg_rdata);
		@(posedge clk);
	endtask

	task pin(input logic [7:0] mask, input logic [7:0] exp);
		@(negedge clk);
		chk("pins", exp, pins & mask);
		@(posedge clk);
	endtask

	task pulse_rx(input logic dir, input int n);
		repeat (n) begin
			rx_cell_in <= !dir;
			rx_cell_out <= dir;
			@(posedge clk);
			rx_cell_in <= 1'b0;
			rx_cell_out <= 1'b0;
			@(posedge clk);
		end
	endtask

	// counts offered bytes with ready held; bounded, enough for one whole cell
	task drain(input int n);
		int cnt;
		cnt = 0;
		tx_out_ready <= 1'b1;
		repeat (400) begin
			@(negedge clk);
			if (tx_out_valid === 1'b1) begin
				if (cnt == 0) chk("first byte", 8'h30, tx_out_data);
				if (cnt == 0) chk("first soc", 8'h01, {7'h00, tx_out_soc});
				cnt++;
			end
		end
		chk("byte count", n[7:0], cnt[7:0]);
		@(posedge clk);
	endtask

	task close_out;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(RX_ADDR_OFFSET, 8'h00);
		rd(RX_STATUS_OFFSET, 8'h01);
		rd(TX_CTRL_OFFSET, 8'h00);
		rd(EVENT_CLEAR_OFFSET, 8'h00);
		rd(8'h50, 8'h00);
		pin(8'h1c, 8'h08);
		$display("reset values done");
		wr(RX_ADDR_OFFSET, 8'hf5);
		rd(RX_ADDR_OFFSET, 8'h15);
		wr(TX_CTRL_OFFSET, 8'h3f);
		rd(TX_CTRL_OFFSET, 8'h38);
		wr(TX_CTRL_OFFSET, 8'h00);
		$display("register access done");
		pulse_rx(1'b0, 4);
		rd(RX_STATUS_OFFSET, 8'h02);
		pin(8'h04, 8'h04);
		rx_addr_in <= 5'h0a;
		repeat (8) @(posedge clk);
		pin(8'h04, 8'h00);
		rx_addr_in <= 5'h15;
		repeat (8) @(posedge clk);
		pin(8'h04, 8'h04);
		wr(RX_STATUS_OFFSET, 8'h80);
		rd(RX_STATUS_OFFSET, 8'h80);
		pulse_rx(1'b1, 5);
		rd(RX_STATUS_OFFSET, 8'h81);
		pin(8'h04, 8'h00);
		wr(RX_STATUS_OFFSET, 8'h00);
		$display("receive queue done");
		wr(TX_CTRL_OFFSET, 8'h20);
		link.send_cell(53, 5);
		drain(53);
		pin(8'h10, 8'h10);
		rd(TX_CTRL_OFFSET, 8'h24);
		rd(TX_CTRL_OFFSET, 8'h20);
		pin(8'h10, 8'h00);
		wr(TX_CTRL_OFFSET, 8'h40);
		link.send_cell(53, 0);
		drain(0);
		rd(TX_CTRL_OFFSET, 8'h44);
		wr(TX_CTRL_OFFSET, 8'h60);
		link.send_cell(53, 2);
		pin(8'h10, 8'h10);
		wr(EVENT_CLEAR_OFFSET, 8'h03);
		pin(8'h10, 8'h10);
		wr(EVENT_CLEAR_OFFSET, 8'h04);
		pin(8'h10, 8'h00);
		rd(TX_CTRL_OFFSET, 8'h60);
		$display("parity handling done");
		wr(TX_CTRL_OFFSET, 8'h08);
		link.send_cell(20, -1);
		link.send_cell(53, -1);
		drain(53);
		pin(8'h10, 8'h10);
		rd(TX_CTRL_OFFSET, 8'h09);
		$display("short cell done");
		tx_out_ready <= 1'b0;
		wr(TX_CTRL_OFFSET, 8'h10);
		repeat (17) link.send_cell(53, -1);
		repeat (8) @(posedge clk);
		pin(8'h0a, 8'h02);
		rd(TX_CTRL_OFFSET, 8'h12);
		wr(TX_CTRL_OFFSET, 8'h90);
		repeat (4) @(posedge clk);
		pin(8'h0a, 8'h08);
		drain(0);
		rd(TX_CTRL_OFFSET, 8'h90);
		wr(TX_CTRL_OFFSET, 8'h00);
		$display("overrun and flush done");
		atm_cell_mode <= 1'b0;
		wr(TX_CTRL_OFFSET, 8'h38);
		link.send_cell(53, 3);
		drain(0);
		pin(8'h1c, 8'h00);
		$display("clear channel done");
		close_out();
	end
endmodule // utopia_cell_queue_ctrl_status_test
